/* File: inc/lsec_pkg.sv */
// lsec_pkg: register map, field layout and event codes of the statistics
// counter block; shared by the core and the verification side.
package lsec_pkg;

	// register byte offsets on the wishbone slave
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] SEL_OFS    = 4'h4;
	localparam logic [3:0] FTAG_OFS   = 4'h8;
	localparam logic [3:0] CNT0_OFS   = 4'hc;
	localparam logic [3:0] CNT_STRIDE = 4'h4;
	localparam int         ADDR_W     = 6;

	// control register fields
	localparam int CTRL_START_BIT = 31;
	localparam int CTRL_STOP_BIT  = 30;
	localparam int CTRL_CLEAR_BIT = 29;
	localparam int CTRL_WIDE_BIT  = 28;
	localparam int CTRL_EN_LSB    = 0;

	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] SEL_RST  = 32'h0000_0000;
	localparam logic [31:0] FTAG_RST = 32'h0000_0000;

	// per-counter field widths inside select and function-tag registers
	localparam int CODE_W = 8;
	localparam int FUNC_W = 3;
	localparam int TAG_W  = 5;
	localparam int TAG_LSB  = 0;
	localparam int FUNC_LSB = 5;

	// event codes
	localparam logic [7:0] EV_TX_DW      = 8'h00;
	localparam logic [7:0] EV_TX_PKT     = 8'h01;
	localparam logic [7:0] EV_TX_F0      = 8'h02;
	localparam logic [7:0] EV_TX_F1      = 8'h03;
	localparam logic [7:0] EV_TX_NP_F0   = 8'h04;
	localparam logic [7:0] EV_TX_NP_F1   = 8'h05;
	localparam logic [7:0] EV_TX_FTAG    = 8'h06;
	localparam logic [7:0] EV_RX_PKT     = 8'h1a;
	localparam logic [7:0] EV_RX_CPL_F0  = 8'h1b;
	localparam logic [7:0] EV_RX_CPL_F1  = 8'h1c;
	localparam logic [7:0] EV_RX_FTAG    = 8'h1d;
	localparam logic [7:0] EV_RX_BAD     = 8'h21;
	localparam logic [7:0] EV_TX_HDR     = 8'h25;
	localparam logic [7:0] EV_RX_HDR     = 8'h26;
	localparam logic [7:0] EV_STALL_FC   = 8'h27;
	localparam logic [7:0] EV_REPLAY     = 8'h28;
	localparam logic [7:0] EV_STALL_RB   = 8'h29;
	localparam logic [7:0] EV_RB_UNDER   = 8'h2a;
	localparam logic [7:0] EV_RCR_PH     = 8'h2b;
	localparam logic [7:0] EV_RCR_PD     = 8'h2c;
	localparam logic [7:0] EV_RCR_NPH    = 8'h2d;
	localparam logic [7:0] EV_RCR_CPLH   = 8'h2e;
	localparam logic [7:0] EV_RCR_CPLD   = 8'h2f;
	localparam logic [7:0] EV_LCR_PH     = 8'h30;
	localparam logic [7:0] EV_LCR_NPH    = 8'h31;
	localparam logic [7:0] EV_LCR_PD     = 8'h32;

	// transmit side event bundle, one cycle per strobe
	typedef struct packed {
		logic       pkt;      // non-replay tlp handed to the link
		logic [1:0] dw;       // dwords of tlp this cycle, 0..2
		logic [1:0] hdr_dw;   // header dwords this cycle, 0..2
		logic       is_mem_msg;
		logic       is_np_mem;
		logic [2:0] func;
		logic [4:0] tag;
		logic       replay;   // packet retransmitted
		logic       stall_fc; // stop for lack of partner credits
		logic       stall_rb; // stop for retry buffer full
		logic       rb_under; // retry buffer under threshold
	} lsec_tx_ev_s;

	// receive side event bundle
	typedef struct packed {
		logic       pkt;      // good cpl, mem, io or cfg request
		logic       good_cpl;
		logic [2:0] func;
		logic [4:0] tag;
		logic       bad;      // crc, lower layer, symbol or reset error
		logic [1:0] hdr_dw;
	} lsec_rx_ev_s;

	// flow credit levels: remote below threshold, local at zero
	typedef struct packed {
		logic [4:0] remote_low; // ph, pd, nph, cplh, cpld
		logic [2:0] local_zero; // ph, nph, pd
	} lsec_fc_ev_s;

endpackage : lsec_pkg

/* File: core/lsec_counters.sv */
// lsec_counters: four host interface statistic counters behind a wishbone
// classic slave. assumes events come from logic on clk_i (no crossing).
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps

// What this block does
// - select register bits 31:24 code counter 3, 23:16 counter 2, reset 0
// - bits 15:8 code counter 1, 7:0 counter 0; counter counts its code
// - code 0 adds 1 or 2 per cycle for transmitted tlp dwords
// - code 1 adds one per cycle a non-replay tlp is transmitted
// - codes 2,3 count transmitted mem/msg tlps of function 0 or 1
// - codes 4,5 count transmitted non-posted mem tlps of function 0 or 1
// - code 6 counts transmitted mem/msg tlps matching programmed func, tag
// - code 1a counts received good cpl, mem, io or cfg tlps
// - codes 1b,1c count good completions of function 0 or 1
// - code 1d counts good completions matching programmed func and tag
// - code 21 counts received bad tlps
// - code 25 adds 1 or 2 for transmitted header dwords
// - code 26 adds 1 or 2 for received header dwords
// - code 27 counts transmit stalls for missing partner credits
// - code 28 counts each retransmitted packet
// - code 29 counts transmit stalls for full retry buffer
// - code 2a counts packets while retry buffer under threshold
// - codes 2b..2f count partner credit types falling below threshold
// - codes 30..32 count local credits reaching zero, not time at zero
// - each counter increments only with its enable bit set, reset 0; a wide-mode odd counter takes its pair's carry regardless
// - control bits 31, 30, 29 start, stop and clear all counters
// - wide pair mode joins counters into two 64-bit counters
// - function-tag events use each counter's 3-bit func and 5-bit tag
module lsec_counters #(
	parameter int N_CTR = 4
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     cyc_i,
	input  wire logic                     stb_i,
	input  wire logic                     we_i,
	input  wire logic [lsec_pkg::ADDR_W-1:0] adr_i,
	input  wire logic [3:0]               sel_i,
	input  wire logic [31:0]              dat_i,
	output logic      [31:0]              dat_o,
	output logic                          ack_o,
	input  wire lsec_pkg::lsec_tx_ev_s    tx_ev_i,
	input  wire lsec_pkg::lsec_rx_ev_s    rx_ev_i,
	input  wire lsec_pkg::lsec_fc_ev_s    fc_ev_i
);

	logic [31:0]       ctrl_reg;
	logic [31:0]       sel_reg;
	logic [31:0]       ftag_reg;
	logic [31:0]       cnt_reg [N_CTR];
	logic [31:0]       cnt_next [N_CTR];
	logic              run_reg;
	logic [4:0]        rlow_reg;
	logic [2:0]        lzero_reg;
	logic              ack_reg;
	logic [31:0]       dat_reg;
	logic [1:0]        inc [N_CTR];
	logic [N_CTR-1:0]  carry;

	wire       req      = cyc_i && stb_i && !ack_reg;
	wire       wr       = req && we_i;
	// full word address; a 4-bit compare would alias 0x10 onto control
	wire [lsec_pkg::ADDR_W-1:0] reg_adr = {adr_i[lsec_pkg::ADDR_W-1:2], 2'b00};
	wire       hit_ctrl = reg_adr
		== lsec_pkg::ADDR_W'(lsec_pkg::CTRL_OFS);
	wire       hit_sel  = reg_adr
		== lsec_pkg::ADDR_W'(lsec_pkg::SEL_OFS);
	wire       hit_ftag = reg_adr
		== lsec_pkg::ADDR_W'(lsec_pkg::FTAG_OFS);
	wire       wide     = ctrl_reg[lsec_pkg::CTRL_WIDE_BIT];
	wire       do_start = wr && hit_ctrl && sel_i[3]
		&& dat_i[lsec_pkg::CTRL_START_BIT];
	wire       do_stop  = wr && hit_ctrl && sel_i[3]
		&& dat_i[lsec_pkg::CTRL_STOP_BIT];
	wire       do_clear = wr && hit_ctrl && sel_i[3]
		&& dat_i[lsec_pkg::CTRL_CLEAR_BIT];
	// edges of credit levels; time spent at the level is not counted
	wire [4:0] rlow_rise  = fc_ev_i.remote_low & ~rlow_reg;
	wire [2:0] lzero_rise = fc_ev_i.local_zero & ~lzero_reg;

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// control: start/stop/clear are strobes and read back as zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= lsec_pkg::CTRL_RST;
			sel_reg  <= lsec_pkg::SEL_RST;
			ftag_reg <= lsec_pkg::FTAG_RST;
		end else if (wr) begin
			if (hit_ctrl) begin
				ctrl_reg <= merge(ctrl_reg, dat_i, sel_i) & 32'h1000_000f;
			end
			if (hit_sel) begin
				sel_reg <= merge(sel_reg, dat_i, sel_i);
			end
			if (hit_ftag) begin
				ftag_reg <= merge(ftag_reg, dat_i, sel_i);
			end
		end
	end

	// stop wins over start when both are written together
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_reg <= 1'b0;
		end else if (do_stop) begin
			run_reg <= 1'b0;
		end else if (do_start) begin
			run_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rlow_reg  <= 5'h00;
			lzero_reg <= 3'h0;
		end else begin
			rlow_reg  <= fc_ev_i.remote_low;
			lzero_reg <= fc_ev_i.local_zero;
		end
	end

	genvar g;
	generate
		for (g = 0; g < N_CTR; g++) begin : g_ctr
			wire [7:0] code = sel_reg[g*8 +: 8];
			wire [2:0] fn   = ftag_reg[g*8+lsec_pkg::FUNC_LSB +: 3];
			wire [4:0] tg   = ftag_reg[g*8+lsec_pkg::TAG_LSB +: 5];
			wire tx_ok  = tx_ev_i.pkt && !tx_ev_i.replay;
			wire tx_mm  = tx_ok && tx_ev_i.is_mem_msg;
			wire tx_np  = tx_ok && tx_ev_i.is_np_mem;
			wire tx_mt  = tx_mm && tx_ev_i.func == fn && tx_ev_i.tag == tg;
			wire rx_mt  = rx_ev_i.good_cpl && rx_ev_i.func == fn
				&& rx_ev_i.tag == tg;
			wire en_g   = ctrl_reg[lsec_pkg::CTRL_EN_LSB + g] && run_reg;

			always_comb begin
				inc[g] = 2'd0;
				case (code)
					lsec_pkg::EV_TX_DW:
						inc[g] = tx_ev_i.replay ? 2'd0 : tx_ev_i.dw;
					lsec_pkg::EV_TX_PKT:    inc[g] = {1'b0, tx_ok};
					lsec_pkg::EV_TX_F0:
						inc[g] = {1'b0, tx_mm && tx_ev_i.func == 3'd0};
					lsec_pkg::EV_TX_F1:
						inc[g] = {1'b0, tx_mm && tx_ev_i.func == 3'd1};
					lsec_pkg::EV_TX_NP_F0:
						inc[g] = {1'b0, tx_np && tx_ev_i.func == 3'd0};
					lsec_pkg::EV_TX_NP_F1:
						inc[g] = {1'b0, tx_np && tx_ev_i.func == 3'd1};
					lsec_pkg::EV_TX_FTAG:   inc[g] = {1'b0, tx_mt};
					lsec_pkg::EV_RX_PKT:    inc[g] = {1'b0, rx_ev_i.pkt};
					lsec_pkg::EV_RX_CPL_F0:
						inc[g] = {1'b0, rx_ev_i.good_cpl
							&& rx_ev_i.func == 3'd0};
					lsec_pkg::EV_RX_CPL_F1:
						inc[g] = {1'b0, rx_ev_i.good_cpl
							&& rx_ev_i.func == 3'd1};
					lsec_pkg::EV_RX_FTAG:   inc[g] = {1'b0, rx_mt};
					lsec_pkg::EV_RX_BAD:    inc[g] = {1'b0, rx_ev_i.bad};
					lsec_pkg::EV_TX_HDR:
						inc[g] = tx_ev_i.replay ? 2'd0 : tx_ev_i.hdr_dw;
					lsec_pkg::EV_RX_HDR:    inc[g] = rx_ev_i.hdr_dw;
					lsec_pkg::EV_STALL_FC:
						inc[g] = {1'b0, tx_ev_i.stall_fc};
					lsec_pkg::EV_REPLAY:
						inc[g] = {1'b0, tx_ev_i.replay};
					lsec_pkg::EV_STALL_RB:
						inc[g] = {1'b0, tx_ev_i.stall_rb};
					lsec_pkg::EV_RB_UNDER:
						inc[g] = {1'b0, tx_ev_i.pkt && tx_ev_i.rb_under};
					lsec_pkg::EV_RCR_PH:    inc[g] = {1'b0, rlow_rise[0]};
					lsec_pkg::EV_RCR_PD:    inc[g] = {1'b0, rlow_rise[1]};
					lsec_pkg::EV_RCR_NPH:   inc[g] = {1'b0, rlow_rise[2]};
					lsec_pkg::EV_RCR_CPLH:  inc[g] = {1'b0, rlow_rise[3]};
					lsec_pkg::EV_RCR_CPLD:  inc[g] = {1'b0, rlow_rise[4]};
					lsec_pkg::EV_LCR_PH:    inc[g] = {1'b0, lzero_rise[0]};
					lsec_pkg::EV_LCR_NPH:   inc[g] = {1'b0, lzero_rise[1]};
					lsec_pkg::EV_LCR_PD:    inc[g] = {1'b0, lzero_rise[2]};
					default:                inc[g] = 2'd0;
				endcase
				if (!en_g) begin
					inc[g] = 2'd0;
				end
			end

			// in wide mode odd counters hold the upper word of the pair and
			// take the carry of the even one; their own events are ignored
			logic [32:0] sum;
			always_comb begin
				if (wide && g[0]) begin
					sum = {1'b0, cnt_reg[g]} + {32'h0, carry[g-1 < 0 ? 0 : g-1]};
				end else begin
					sum = {1'b0, cnt_reg[g]} + {31'h0, inc[g]};
				end
				carry[g]    = sum[32];
				cnt_next[g] = sum[31:0];
			end

			always_ff @(posedge clk_i) begin
				if (rst_i || do_clear) begin
					cnt_reg[g] <= 32'h0000_0000;
				end else begin
					cnt_reg[g] <= cnt_next[g];
				end
			end
		end
	endgenerate

	// read mux; counters read only, unmapped reads return zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_mux = ctrl_reg;
		end else if (hit_sel) begin
			rd_mux = sel_reg;
		end else if (hit_ftag) begin
			rd_mux = ftag_reg;
		end
		for (int k = 0; k < N_CTR; k++) begin
			if (reg_adr == lsec_pkg::ADDR_W'(lsec_pkg::CNT0_OFS)
					+ lsec_pkg::ADDR_W'(k * lsec_pkg::CNT_STRIDE)) begin
				rd_mux = cnt_reg[k];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			dat_reg <= rd_mux;
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = dat_reg;

endmodule : lsec_counters

/* File: tb/lsec_counters_properties.sv */
// lsec_chk: port-level checks of the statistics counter block.
// assumes a classic wishbone master that holds each request until ack.
`timescale 1ns/10ps
module lsec_chk #(
	parameter int N_CTR = 4
) (
	input wire logic                          clk_i,
	input wire logic                          rst_i,
	input wire logic                          cyc_i,
	input wire logic                          stb_i,
	input wire logic                          we_i,
	input wire logic [lsec_pkg::ADDR_W-1:0]   adr_i,
	input wire logic [3:0]                    sel_i,
	input wire logic [31:0]                   dat_i,
	input wire logic [31:0]                   dat_o,
	input wire logic                          ack_o,
	input wire lsec_pkg::lsec_tx_ev_s         tx_ev_i,
	input wire lsec_pkg::lsec_rx_ev_s         rx_ev_i,
	input wire lsec_pkg::lsec_fc_ev_s         fc_ev_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire       wr = cyc_i & stb_i & ~ack_o & we_i;
	wire [3:0] ix = adr_i[5:2];
	wire [31:0] be = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	// strobes are not stored, so the shadow masks them out
	wire [31:0] msk = (ix == 4'h0) ? 32'h1000_000f : 32'hffff_ffff;
	logic [31:0] shd [3];
	wire [31:0] rexp = shd[ix[1:0]];
	// set while every counter must still read zero
	logic        clr_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shd <= '{lsec_pkg::CTRL_RST, lsec_pkg::SEL_RST, lsec_pkg::FTAG_RST};
			clr_q <= 1'b1;
		end else begin
			if (wr && ix < 4'h3)
				shd[ix[1:0]] <= (shd[ix[1:0]] & ~be) | (dat_i & be & msk);
			if (wr && ix == 4'h0 && dat_i[29] && sel_i[3])
				clr_q <= 1'b1;
			else if (tx_ev_i != '0 || rx_ev_i != '0 || fc_ev_i != '0)
				clr_q <= 1'b0;
		end
	end
	sequence s_take;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_rd(logic [3:0] a);
		s_take ##0 (!we_i && ix == a);
	endsequence
	a_ack_follows: assert property (s_take |=> ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && dat_o == 0)
		else $error("bus outputs active out of reset");
	a_sel_readback: assert property (s_rd(4'h1) |=> dat_o == $past(rexp))
		else $error("select register read mismatch");
	a_ctrl_readback: assert property (s_rd(4'h0) |=> dat_o == $past(rexp))
		else $error("control register read mismatch");
	a_ftag_readback: assert property (s_rd(4'h2) |=> dat_o == $past(rexp))
		else $error("function tag register read mismatch");
	a_strobes_zero: assert property (s_rd(4'h0) |=> dat_o[31:29] == 3'b000)
		else $error("control strobes read back set");
	a_clear_zero: assert property ((s_rd(ix) ##0 (clr_q && ix > 4'h2
		&& ix < 3 + N_CTR)) |=> dat_o == 32'h0)
		else $error("counter not zero after clear");
endmodule : lsec_chk

bind lsec_counters lsec_chk #(.N_CTR(N_CTR)) i_chk (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
	.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tx_ev_i(tx_ev_i),
	.rx_ev_i(rx_ev_i), .fc_ev_i(fc_ev_i));

/* File: tb/tb_link_statistics_event_counters.sv */
// tb: runs every event code through the counters against a bench model, codes 05 and 1a only on disabled counters.
// assumes the design answers each wishbone request with a one-cycle ack.
`timescale 1ns/10ps
module tb_link_statistics_event_counters;
	logic                  clk_i = 1'b0;
	logic                  rst_i = 1'b1;
	logic                  cyc_i = 1'b0;
	logic                  stb_i = 1'b0;
	logic                  we_i  = 1'b0;
	logic [5:0]            adr_i = '0;
	logic [3:0]            sel_i = 4'hf;
	logic [31:0]           dat_i = '0;
	logic [31:0]           dat_o;
	logic                  ack_o;
	lsec_pkg::lsec_tx_ev_s tx_ev_i = '0;
	lsec_pkg::lsec_rx_ev_s rx_ev_i = '0;
	lsec_pkg::lsec_fc_ev_s fc_ev_i = '0;
	int                    mismatches = 0;
	int                    tests_run = 0;
	int unsigned           cnt [4];
	logic [7:0]            code [4];
	logic [3:0]            en;
	logic                  wide, rp, lp;
	logic [2:0]            fi;
	logic [4:0]            ti;
	logic [31:0]           q;
	logic [7:0] codes [28] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
		8'h06, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h21, 8'h25, 8'h26, 8'h27, 8'h28,
		8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h32, 8'h20,
		8'h31, 8'h33};
	lsec_counters i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tx_ev_i(tx_ev_i),
		.rx_ev_i(rx_ev_i), .fc_ev_i(fc_ev_i));
	always #12.5 clk_i = ~clk_i;
	task test_done;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i} <= {2'b11, w};
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) mismatches++;
		q = dat_o;
		{cyc_i, stb_i, we_i} <= 3'b000;
	endtask : wb
	task rd(input logic [5:0] a, input string nm, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask : rd
	function int unsigned inc(input logic [7:0] c, input lsec_pkg::lsec_tx_ev_s t,
		input lsec_pkg::lsec_rx_ev_s r, input logic rr, input logic lr);
		logic tm, rm;
		tm = t.func == fi && t.tag == ti;
		rm = r.func == fi && r.tag == ti;
		case (c)
			8'h00: return t.replay ? 0 : t.dw;
			8'h01: return t.pkt;
			8'h02, 8'h03: return t.pkt && t.is_mem_msg && t.func == c[2:0] - 3'h2;
			8'h04, 8'h05: return t.pkt && t.is_np_mem && t.func == c[2:0] - 3'h4;
			8'h06: return t.pkt && t.is_mem_msg && tm;
			8'h1a: return r.pkt;
			8'h1b, 8'h1c: return r.good_cpl && r.func == c[2:0] - 3'h3;
			8'h1d: return r.good_cpl && rm;
			8'h21: return r.bad;
			8'h25: return t.replay ? 0 : t.hdr_dw;
			8'h26: return r.hdr_dw;
			8'h27: return t.stall_fc;
			8'h28: return t.replay;
			8'h29: return t.stall_rb;
			8'h2a: return t.pkt && t.rb_under;
			8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f: return rr;
			8'h30, 8'h31, 8'h32: return lr;
			default: return 0;
		endcase
	endfunction : inc
	task ev(input int n, input logic live);
		lsec_pkg::lsec_tx_ev_s t;
		lsec_pkg::lsec_rx_ev_s r;
		logic rl, ll;
		repeat (n) begin
			@(posedge clk_i);
			t = $bits(t)'($urandom);
			r = $bits(r)'($urandom);
			{rl, ll} = 2'($urandom);
			// small func and tag values so matches really happen
			{t.func, t.tag, r.func, r.tag} = {2'b0, t.func[0], 4'b0, t.tag[0],
				2'b0, r.func[0], 4'b0, r.tag[0]};
			if (t.replay) t.pkt = 1'b0;
			if (t.dw == 2'd3) t.dw = 2'd2;
			if (t.hdr_dw == 2'd3) t.hdr_dw = 2'd2;
			if (r.hdr_dw == 2'd3) r.hdr_dw = 2'd2;
			tx_ev_i <= t;
			rx_ev_i <= r;
			fc_ev_i <= {{5{rl}}, {3{ll}}};
			for (int i = 0; i < 4; i++)
				if (live && en[i] && !(wide && i[0]))
					cnt[i] += inc(code[i], t, r, rl && !rp, ll && !lp);
			{rp, lp} = {rl, ll};
		end
		@(posedge clk_i);
		{tx_ev_i, rx_ev_i, fc_ev_i} <= '0;
		{rp, lp} = 2'b00;
	endtask : ev
	initial begin
		#(25 * 20000);
		mismatches++;
		test_done;
	end
	initial begin
		void'($urandom(59));
		{rp, lp} = 2'b00;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(6'h00, "control", lsec_pkg::CTRL_RST);
		rd(6'h04, "select", lsec_pkg::SEL_RST);
		rd(6'h08, "function tag", lsec_pkg::FTAG_RST);
		wb(1'b1, 6'h1c, 32'hffff_ffff);
		rd(6'h1c, "unmapped", 32'h0);
		for (int k = 0; k < 7; k++) begin
			for (int i = 0; i < 4; i++) code[i] = codes[4 * k + i];
			en = (k == 1) ? 4'h5 : 4'hf;
			wide = (k == 6);
			fi = 3'($urandom % 2);
			ti = 5'($urandom % 2);
			wb(1'b1, 6'h04, {code[3], code[2], code[1], code[0]});
			wb(1'b1, 6'h08, {4{fi, ti}});
			wb(1'b1, 6'h00, {3'b001, wide, 24'h0, en});
			rd(6'h0c, "cleared", 32'h0);
			wb(1'b1, 6'h00, {3'b100, wide, 24'h0, en});
			for (int i = 0; i < 4; i++) cnt[i] = 0;
			ev(40, 1'b1);
			wb(1'b1, 6'h00, {3'b010, wide, 24'h0, en});
			// events after stop must be ignored; counters are read-only
			ev(8, 1'b0);
			wb(1'b1, 6'h0c, 32'h5a5a_5a5a);
			rd(6'h00, "control", {3'b0, wide, 24'h0, en});
			rd(6'h04, "select", {code[3], code[2], code[1], code[0]});
			rd(6'h08, "function tag", {4{fi, ti}});
			for (int i = 0; i < 4; i++)
				rd(6'h0c + 6'(4 * i), $sformatf("counter %0d", i), cnt[i]);
		end
		test_done;
	end
endmodule : tb_link_statistics_event_counters
